/* rtl/ivtd_pkg.sv */
// Package of the interrupt vector and trap dispatch block.
// Assumes a single system clock and a synchronous active-high reset.
package ivtd_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NODES    = 16;   // Interrupt nodes in this instance
  localparam int unsigned TRAPS    = 8;    // Hardware trap sources
  localparam int unsigned NODE_W   = 4;
  localparam int unsigned TRAP_W   = 3;
  localparam int unsigned PRIO_W   = 4;    // Sixteen priority levels
  localparam int unsigned ADDR_W   = 6;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned NUM_W    = 7;    // Trap number width
  localparam int unsigned SEG_W    = 8;
  localparam int unsigned OFS_W    = 16;
  localparam int unsigned VEC_W    = 24;
  localparam int unsigned SPC_W    = 2;

  // ----------------------------------------------------------------
  // Register offsets (word registers on the plain port)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_NODE0    = 6'h00; // Node controls 0x00..0x0f
  localparam logic [ADDR_W-1:0] OFS_VECTOR_SEGMENT_REGISTER   = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_CPUCFG1  = 6'h11;
  localparam logic [ADDR_W-1:0] OFS_TRAPFLAG = 6'h12;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h13;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 6'h15;

  // ----------------------------------------------------------------
  // Node control fields
  // ----------------------------------------------------------------
  localparam int unsigned NC_PRIO_LSB = 0;
  localparam int unsigned NC_IE_BIT   = 6;
  localparam int unsigned NC_IR_BIT   = 7;
  localparam int unsigned SPC_LSB     = 0;   // Spacing field in config reg
  localparam int unsigned STAT_ST_LSB   = 0; // State code in status reg
  localparam int unsigned STAT_PRIO_LSB = 4; // Running priority in status reg

  // ----------------------------------------------------------------
  // Reset values and spacing codes
  // ----------------------------------------------------------------
  localparam logic [SEG_W-1:0]  VECTOR_SEGMENT_REGISTER_RST   = 8'h00;
  localparam logic [SPC_W-1:0]  SPC_DEFAULT  = 2'h0;  // Four bytes apart
  localparam logic [NUM_W-1:0]  NODE_NUM_BASE = 7'h50; // Arbitrary base number
  localparam logic [TRAP_W-1:0] TRAP_CLASS_B = 3'h4;  // Traps 4..7 share one vector
  localparam logic [NUM_W-1:0]  TRAP_NUM_B   = 7'h0a;
  localparam logic [NUM_W-1:0]  TRAP_NUM_STEP = 7'h02;

  // Interrupt status bits
  localparam int unsigned EV_TRAP = 0;
  localparam int unsigned EV_INT  = 1;
  localparam int unsigned EV_W    = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_INT  = 3'h2,
    ST_TRAP = 3'h4
  } ivtd_state_t;

  typedef struct packed {
    logic              ir;
    logic              ie;
    logic [PRIO_W-1:0] prio;
  } ivtd_node_t;

  typedef struct packed {
    logic              valid;
    logic              is_trap;
    logic [NUM_W-1:0]  num;
    logic [VEC_W-1:0]  addr;
  } ivtd_take_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } ivtd_bus_t;

endpackage

/* rtl/ivtd_vec_gen.sv */
// Vector address former: segment, trap number and spacing.
// Assumes pure combinational use from the dispatch core.
module ivtd_vec_gen (
  // Inputs
  input  wire logic [ivtd_pkg::SEG_W-1:0] seg_i,
  input  wire logic [ivtd_pkg::SPC_W-1:0] spc_i,
  input  wire logic [ivtd_pkg::NUM_W-1:0] num_i,
  // Output
  output logic      [ivtd_pkg::VEC_W-1:0] addr_o
);

  logic [ivtd_pkg::OFS_W-1:0] ofs;

  // Offset is number times four, doubled per spacing step
  always_comb begin
    ofs    = ivtd_pkg::OFS_W'({num_i, 2'b00}) << spc_i;
    addr_o = {seg_i, ofs};
  end

endmodule

/* rtl/ivtd_core.sv */
// Interrupt and hardware trap dispatch core with register port.
// Assumes the CPU pulses ack_i when it enters and reti_i on return.
// Assumes requests and strobes come from logic on the same clock,
// so nothing here is synchronised.
//
// Summary of operation
// - Vector table lies in the segment held by the vector segment register.
// - Spacing field scales every vector offset.
// - Default spacing puts vectors four bytes apart: offset is number times four.
// - Hardware traps dispatch at once, no mask applies.
// - Each trap sets its own bit in the trap flag register.
// - Trap preempts everything unless an equal or higher trap is in service.
// - Standard interrupts cannot preempt a running trap service.
// - Each node has request, enable and a sixteen-level priority field.
// - Accepted service is preempted only by strictly higher priority.
// - Software setting a request bit raises that node's request.
//
// Our own choices: the register offsets and the strobed register port.
module ivtd_core (
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_i,
  // Register port
  input  wire logic [ivtd_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [ivtd_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                          we_i,
  input  wire logic                          re_i,
  output logic      [ivtd_pkg::DATA_W-1:0]   rdata_o,
  // Request sources (same clock domain, one-cycle pulses)
  input  wire logic [ivtd_pkg::NODES-1:0]    node_req_i,
  input  wire logic [ivtd_pkg::TRAPS-1:0]    trap_req_i,
  // CPU side
  input  wire logic                          ack_i,
  input  wire logic                          reti_i,
  output logic                               take_valid_o,
  output logic                               take_trap_o,
  output logic      [ivtd_pkg::NUM_W-1:0]    take_num_o,
  output logic      [ivtd_pkg::VEC_W-1:0]    take_addr_o,
  output logic      [ivtd_pkg::PRIO_W-1:0]   cur_prio_o,
  // Interrupt
  output logic                               irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // All state in one struct: reset and next state cannot drift
  typedef struct packed {
    // Software-visible registers, plus the internal trap pending bits
    ivtd_pkg::ivtd_node_t [ivtd_pkg::NODES-1:0] node;
    logic [ivtd_pkg::SEG_W-1:0]   seg;
    logic [ivtd_pkg::SPC_W-1:0]   spc;
    logic [ivtd_pkg::TRAPS-1:0]   tflag;
    logic [ivtd_pkg::TRAPS-1:0]   tpend;
    logic [ivtd_pkg::EV_W-1:0]    ev_stat;
    logic [ivtd_pkg::EV_W-1:0]    ev_mask;
    // Service tracking
    ivtd_pkg::ivtd_state_t        st;
    logic [ivtd_pkg::PRIO_W-1:0]  prio;      // Priority of running service
    logic [ivtd_pkg::TRAP_W-1:0]  trap_idx;  // Trap in service
    logic                         saved_int; // Interrupt preempted by a trap
    logic [ivtd_pkg::PRIO_W-1:0]  saved_prio;
    // Pending offer
    logic                         offer;     // Offer presented, awaiting ack
    logic                         offer_trap;
    logic [ivtd_pkg::NODE_W-1:0]  offer_node;
    logic [ivtd_pkg::TRAP_W-1:0]  offer_tidx;
    logic [ivtd_pkg::NUM_W-1:0]   offer_num;
    // Read data flop
    logic [ivtd_pkg::DATA_W-1:0]  rdata;
  } ivtd_regs_t;

  // Registered state and its next value
  ivtd_regs_t q, d;
  logic [ivtd_pkg::VEC_W-1:0] vec_addr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Node control registers sit at the bottom of the map
  function automatic logic is_node(
      input logic [ivtd_pkg::ADDR_W-1:0] a);
    return a < ivtd_pkg::OFS_NODE0 + ivtd_pkg::ADDR_W'(ivtd_pkg::NODES);
  endfunction

  // Lowest index wins: trap 0 has the highest trap priority
  // An empty vector gives 0; callers test for a bit first
  function automatic logic [ivtd_pkg::TRAP_W-1:0] first_trap(
      input logic [ivtd_pkg::TRAPS-1:0] v);
    logic [ivtd_pkg::TRAP_W-1:0] r;
    r = '0;
    for (int i = ivtd_pkg::TRAPS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = ivtd_pkg::TRAP_W'(i);
      end
    end
    return r;
  endfunction

  // Class B traps share one number; class A numbers step by two
  // Numbers double as vector slots
  function automatic logic [ivtd_pkg::NUM_W-1:0] trap_num(
      input logic [ivtd_pkg::TRAP_W-1:0] t);
    logic [ivtd_pkg::NUM_W-1:0] r;
    r = ivtd_pkg::TRAP_NUM_STEP * (ivtd_pkg::NUM_W'(t) + 7'h01);
    if (t >= ivtd_pkg::TRAP_CLASS_B) begin
      r = ivtd_pkg::TRAP_NUM_B;
    end
    return r;
  endfunction

  // Mask of trap indices of priority strictly above t; the caller ANDs in pending
  // Equal priority never preempts: a retrigger waits
  function automatic logic [ivtd_pkg::TRAPS-1:0] above(
      input logic [ivtd_pkg::TRAP_W-1:0] t);
    logic [ivtd_pkg::TRAPS-1:0] r;
    r = '0;
    for (int i = 0; i < ivtd_pkg::TRAPS; i++) begin
      r[i] = (ivtd_pkg::TRAP_W'(i) < t);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Vector former
  // ----------------------------------------------------------------
  // Fed from offer flops, so the address settles with valid
  ivtd_vec_gen u_vec (
    .seg_i  (q.seg),
    .spc_i  (q.spc),
    .num_i  (q.offer_num),
    .addr_o (vec_addr)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic                        hit_node;
    logic [ivtd_pkg::NODE_W-1:0] win;
    logic [ivtd_pkg::PRIO_W-1:0] win_prio;
    logic                        int_ok;
    logic                        trap_ok;
    logic [ivtd_pkg::TRAP_W-1:0] tsel;
    logic [ivtd_pkg::NODE_W-1:0] widx;
    logic [ivtd_pkg::EV_W-1:0]   ev_set;
    logic [ivtd_pkg::TRAPS-1:0]  tall;

    // Scratch values first, so no path leaves one unset
    hit_node = 1'b0;
    win      = '0;
    win_prio = '0;
    int_ok   = 1'b0;
    trap_ok  = 1'b0;
    tsel     = '0;
    widx     = wdata_i[ivtd_pkg::NODE_W-1:0];
    ev_set   = '0;
    tall     = '0;
    d        = q;
    d.rdata  = '0;

    // Register writes first so hardware sets below win over clears
    // A node write replaces the whole control word; a same-cycle
    // request pulse sets the flag again below
    if (we_i) begin
      if (is_node(addr_i)) begin
        widx = addr_i[ivtd_pkg::NODE_W-1:0];
        d.node[widx].ir   = wdata_i[ivtd_pkg::NC_IR_BIT];
        d.node[widx].ie   = wdata_i[ivtd_pkg::NC_IE_BIT];
        d.node[widx].prio = wdata_i[ivtd_pkg::NC_PRIO_LSB +: ivtd_pkg::PRIO_W];
      end else if (addr_i == ivtd_pkg::OFS_VECTOR_SEGMENT_REGISTER) begin
        d.seg = wdata_i[ivtd_pkg::SEG_W-1:0];
      end else if (addr_i == ivtd_pkg::OFS_CPUCFG1) begin
        d.spc = wdata_i[ivtd_pkg::SPC_LSB +: ivtd_pkg::SPC_W];
      end else if (addr_i == ivtd_pkg::OFS_TRAPFLAG) begin
        // Write one to clear
        d.tflag = q.tflag & ~wdata_i[ivtd_pkg::TRAPS-1:0];
      end else if (addr_i == ivtd_pkg::OFS_IRQ_STAT) begin
        d.ev_stat = q.ev_stat & ~wdata_i[ivtd_pkg::EV_W-1:0];
      end else if (addr_i == ivtd_pkg::OFS_IRQ_MASK) begin
        d.ev_mask = wdata_i[ivtd_pkg::EV_W-1:0];
      end
    end

    // Peripheral requests latch into request flags
    // Flag stays until accepted or rewritten
    for (int i = 0; i < ivtd_pkg::NODES; i++) begin
      if (node_req_i[i]) begin
        d.node[i].ir = 1'b1;
      end
    end

    // Traps flag and pend with no mask
    // Flag set beats a same-cycle clearing write
    d.tflag = d.tflag | trap_req_i;
    d.tpend = q.tpend | trap_req_i;

    // Fresh pulses count at once: no extra cycle to the offer
    tall    = q.tpend | trap_req_i;

    // Highest enabled request; lower index breaks ties
    // Downward scan: an equal priority lower down takes over
    for (int i = ivtd_pkg::NODES - 1; i >= 0; i--) begin
      if (q.node[i].ir && q.node[i].ie && (!hit_node || q.node[i].prio >= win_prio)) begin
        hit_node = 1'b1;
        win      = ivtd_pkg::NODE_W'(i);
        win_prio = q.node[i].prio;
      end
    end

    // Strictly higher than running priority, never inside a trap
    // Priority zero never beats an idle CPU
    int_ok = hit_node && (win_prio > q.prio) && (q.st != ivtd_pkg::ST_TRAP);

    // Trap admitted unless an equal or higher trap runs
    // A waiting lower trap is offered after the running one returns
    tsel    = first_trap(tall);
    trap_ok = (tall != '0) &&
              ((q.st != ivtd_pkg::ST_TRAP) || ((tall & above(q.trap_idx)) != '0));

    // Offer: a trap replaces an interrupt offer unless the CPU acks that offer in the same cycle
    // An interrupt offer is not withdrawn for a later, higher node;
    // that node preempts right after entry. One offer register is
    // traded for that extra entry.
    if (!q.offer || (!q.offer_trap && trap_ok)) begin
      // Drop, then refill from the best candidate
      d.offer = 1'b0;
      if (trap_ok) begin
        // Trap number also picks the vector slot
        d.offer      = 1'b1;
        d.offer_trap = 1'b1;
        d.offer_tidx = tsel;
        d.offer_num  = trap_num(tsel);
      end else if (int_ok) begin
        // Node numbers follow the node index
        d.offer      = 1'b1;
        d.offer_trap = 1'b0;
        d.offer_node = win;
        d.offer_num  = ivtd_pkg::NODE_NUM_BASE + ivtd_pkg::NUM_W'(win);
      end
    end

    // CPU accepts the offer; accept beats a return
    // A trap entry keeps one interrupted level so that
    // its return can resume it
    if (q.offer && ack_i) begin
      d.offer = 1'b0;
      if (q.offer_trap) begin
        // A same-cycle pulse of this trap stays pending
        d.tpend[q.offer_tidx] = trap_req_i[q.offer_tidx];
        d.saved_int  = (q.st == ivtd_pkg::ST_INT);
        d.saved_prio = q.prio;
        d.trap_idx   = q.offer_tidx;
        d.st         = ivtd_pkg::ST_TRAP;
        ev_set[ivtd_pkg::EV_TRAP] = 1'b1;
      end else begin
        // Flag drops unless a new pulse came
        d.node[q.offer_node].ir = node_req_i[q.offer_node];
        d.prio = q.node[q.offer_node].prio;
        d.st   = ivtd_pkg::ST_INT;
        ev_set[ivtd_pkg::EV_INT] = 1'b1;
      end
    end else if (reti_i) begin
      // Single-level return; nested interrupts beyond one are not tracked
      // Limitation: a trap nested in a trap returns to idle
      case (q.st)
        ivtd_pkg::ST_TRAP: begin
          // Resume the interrupted level, if any
          d.st   = q.saved_int ? ivtd_pkg::ST_INT : ivtd_pkg::ST_IDLE;
          d.prio = q.saved_int ? q.saved_prio : '0;
        end
        ivtd_pkg::ST_INT: begin
          d.st   = ivtd_pkg::ST_IDLE;
          d.prio = '0;
        end
        default: begin
          // Stray return: stay idle
          d.st   = ivtd_pkg::ST_IDLE;
        end
      endcase
    end

    // Sticky events, set beats clear
    // One event per entry, not per request
    d.ev_stat = d.ev_stat | ev_set;

    // Read data, one cycle later
    // Idle and unmapped reads give zero, never stale data
    if (re_i) begin
      if (is_node(addr_i)) begin
        widx = addr_i[ivtd_pkg::NODE_W-1:0];
        d.rdata[ivtd_pkg::NC_IR_BIT] = q.node[widx].ir;
        d.rdata[ivtd_pkg::NC_IE_BIT] = q.node[widx].ie;
        d.rdata[ivtd_pkg::NC_PRIO_LSB +: ivtd_pkg::PRIO_W] = q.node[widx].prio;
      end else if (addr_i == ivtd_pkg::OFS_VECTOR_SEGMENT_REGISTER) begin
        d.rdata[ivtd_pkg::SEG_W-1:0] = q.seg;
      end else if (addr_i == ivtd_pkg::OFS_CPUCFG1) begin
        d.rdata[ivtd_pkg::SPC_LSB +: ivtd_pkg::SPC_W] = q.spc;
      end else if (addr_i == ivtd_pkg::OFS_TRAPFLAG) begin
        d.rdata[ivtd_pkg::TRAPS-1:0] = q.tflag;
      end else if (addr_i == ivtd_pkg::OFS_IRQ_STAT) begin
        d.rdata[ivtd_pkg::EV_W-1:0] = q.ev_stat;
      end else if (addr_i == ivtd_pkg::OFS_IRQ_MASK) begin
        d.rdata[ivtd_pkg::EV_W-1:0] = q.ev_mask;
      end else if (addr_i == ivtd_pkg::OFS_STATUS) begin
        // State code and running priority side by side
        d.rdata[ivtd_pkg::STAT_ST_LSB +: $bits(ivtd_pkg::ivtd_state_t)] = q.st;
        d.rdata[ivtd_pkg::STAT_PRIO_LSB +: ivtd_pkg::PRIO_W] = q.prio;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset to constants only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q       <= '0;
      q.seg   <= ivtd_pkg::VECTOR_SEGMENT_REGISTER_RST;
      q.spc   <= ivtd_pkg::SPC_DEFAULT;
      q.st    <= ivtd_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Handshake valid combinational from offer flop; data from flops
  // Offer fields hold until ack or until a trap replaces an interrupt offer, so the CPU may sample late
  assign take_valid_o = q.offer;
  assign take_trap_o  = q.offer_trap;
  assign take_num_o   = q.offer_num;
  assign take_addr_o  = vec_addr;
  assign cur_prio_o   = q.prio;
  assign rdata_o      = q.rdata;

  // Level interrupt while an unmasked event is set
  assign irq_o        = |(q.ev_stat & q.ev_mask);

endmodule

/* verification/ivtd_core_props.sv */
// Checker for the dispatch core, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
module ivtd_core_props (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  // Register port
  input wire logic [5:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        we_i,
  input wire logic        re_i,
  input wire logic [15:0] rdata_o,
  // Requests and CPU side
  input wire logic [15:0] node_req_i,
  input wire logic [7:0]  trap_req_i,
  input wire logic        ack_i,
  input wire logic        reti_i,
  input wire logic        take_valid_o,
  input wire logic        take_trap_o,
  input wire logic [6:0]  take_num_o,
  input wire logic [23:0] take_addr_o,
  input wire logic [3:0]  cur_prio_o,
  input wire logic        irq_o
);
  logic [7:0]  seg_q;
  logic [1:0]  spc_q;
  logic [3:0]  stk_q;
  logic [2:0]  lvl_q;
  logic        in_trap;
  logic [6:0]  tnum;
  logic [15:0] ofs;

  // Shadow of vector settings and service nesting (top of stack in bit 0)
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      seg_q <= 8'h00;
      spc_q <= 2'h0;
      stk_q <= 4'h0;
      lvl_q <= 3'h0;
    end else begin
      if (we_i && addr_i == 6'h10) seg_q <= wdata_i[7:0];
      if (we_i && addr_i == 6'h11) spc_q <= wdata_i[1:0];
      if (ack_i && take_valid_o) begin
        stk_q <= {stk_q[2:0], take_trap_o};
        lvl_q <= lvl_q + 3'h1;
      end else if (reti_i && lvl_q != 3'h0) begin
        stk_q <= {1'b0, stk_q[3:1]};
        lvl_q <= stk_q[0] ? lvl_q - 3'h1 : 3'h0; // Nested ints return to idle
      end
    end
  end

  // Expected number of the highest trap request
  always_comb begin
    tnum = 7'h0a;
    for (int i = 3; i >= 0; i--) begin
      if (trap_req_i[i]) tnum = 7'(2 * i + 2);
    end
  end
  assign in_trap = lvl_q != 3'h0 && stk_q[0];
  assign ofs     = (16'(take_num_o) << 2) << spc_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_trap_offer;
    trap_req_i != 8'h00 && !in_trap && !ack_i && !reti_i && !(take_valid_o && take_trap_o)
      |=> take_valid_o && take_trap_o && take_num_o == $past(tnum);
  endproperty
  a_trap_offer: assert property (p_trap_offer)
    else $error("trap not offered in the next cycle");
  property p_vec_addr;
    take_valid_o |-> take_addr_o == {seg_q, ofs};
  endproperty
  a_vec_addr: assert property (p_vec_addr)
    else $error("vector address wrong");
  property p_rdata_idle;
    !re_i |=> rdata_o == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data without a read");
  property p_rdata_unmapped;
    re_i && addr_i > 6'h15 |=> rdata_o == 16'h0000;
  endproperty
  a_rdata_unmapped: assert property (p_rdata_unmapped)
    else $error("unmapped read not zero");
  property p_offer_hold;
    take_valid_o && !ack_i && !we_i && !reti_i && trap_req_i == 8'h00
      && node_req_i == 16'h0000 && $past(node_req_i) == 16'h0000
      |=> take_valid_o && $stable(take_num_o);
  endproperty
  a_offer_hold: assert property (p_offer_hold)
    else $error("offer dropped before acceptance");
  property p_no_int_in_trap;
    in_trap |-> !(take_valid_o && !take_trap_o);
  endproperty
  a_no_int_in_trap: assert property (p_no_int_in_trap)
    else $error("interrupt offered during trap service");
  property p_idle_prio;
    lvl_q == 3'h0 |-> cur_prio_o == 4'h0;
  endproperty
  a_idle_prio: assert property (p_idle_prio)
    else $error("priority not zero when idle");
  property p_reset_clean;
    $fell(rst_i) |-> !take_valid_o && !irq_o && rdata_o == 16'h0000;
  endproperty
  a_reset_clean: assert property (p_reset_clean)
    else $error("outputs not clear after reset");
endmodule

bind ivtd_core ivtd_core_props u_props (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .we_i,
  .re_i, .rdata_o, .node_req_i, .trap_req_i, .ack_i, .reti_i, .take_valid_o,
  .take_trap_o, .take_num_o, .take_addr_o, .cur_prio_o, .irq_o);

/* verification/ivtd_cpu_model.sv */
// CPU core model: accepts offers and returns from service.
// Assumes the bench sets the accept delay and asks for returns.
module ivtd_cpu_model (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Control from the bench
  input  wire logic [1:0] dly_i,
  input  wire logic       ret_req_i,
  // Dispatch side
  input  wire logic       take_valid_i,
  output logic            ack_o,
  output logic            reti_o
);
  logic [1:0] cnt_q;

  // Accept after a settable wait, so slow and prompt CPUs both occur
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q  <= 2'h0;
      ack_o  <= 1'b0;
      reti_o <= 1'b0;
    end else begin
      ack_o  <= take_valid_i && !ack_o && cnt_q >= dly_i;
      cnt_q  <= (!take_valid_i || ack_o) ? 2'h0 : cnt_q + {1'b0, cnt_q != 2'h3};
      reti_o <= ret_req_i;
    end
  end
endmodule

/* verification/tb_top.sv */
// Bench for the dispatch core with a CPU model.
// Assumes a 250 MHz clock and synchronous reset.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic [15:0] nreq = 16'h0000;
  logic [7:0]  treq = 8'h00;
  logic [1:0]  dly = 2'h0;
  logic        retq = 1'b0;
  logic [15:0] rdata;
  logic        ack, reti, tv, tt, irq;
  logic [6:0]  tn;
  logic [23:0] ta;
  logic [3:0]  cp;
  logic [7:0]  seg = 8'h00;
  logic [1:0]  spc = 2'h0;
  int          err_count = 0;
  int          n_compared = 0;

  always #2 clk = ~clk;

  ivtd_core dut (.clk_sys_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .we_i(we),
    .re_i(re), .rdata_o(rdata), .node_req_i(nreq), .trap_req_i(treq), .ack_i(ack),
    .reti_i(reti), .take_valid_o(tv), .take_trap_o(tt), .take_num_o(tn),
    .take_addr_o(ta), .cur_prio_o(cp), .irq_o(irq));
  ivtd_cpu_model u_cpu (.clk_sys_i(clk), .rst_i(rst), .dly_i(dly), .ret_req_i(retq),
    .take_valid_i(tv), .ack_o(ack), .reti_o(reti));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rc(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic pn(input int k);
    @(posedge clk);
    nreq <= 16'h0001 << k;
    @(posedge clk);
    nreq <= 16'h0000;
  endtask
  task automatic pt(input int k);
    @(posedge clk);
    treq <= 8'h01 << k;
    @(posedge clk);
    treq <= 8'h00;
  endtask
  task automatic ret();
    @(posedge clk);
    retq <= 1'b1;
    @(posedge clk);
    retq <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic noff(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 chk(tv, 1'b0);
    end
  endtask
  // Wait for an offer, judge it, then let the CPU model accept it
  task automatic offer(input logic t, input logic [6:0] n);
    int i;
    i = 0;
    #1;
    while (tv !== 1'b1 && i < 20) begin
      @(posedge clk);
      #1 i++;
    end
    chk(tv, 1'b1);
    chk(tt, t);
    chk(tn, n);
    chk(ta, {seg, (16'(n) << 2) << spc});
    i = 0;
    while (tv !== 1'b0 && i < 20) begin
      @(posedge clk);
      #1 i++;
    end
    chk(tv, 1'b0);
  endtask
  task automatic print_verdict();
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rc(6'h10, 16'h0000);
    rc(6'h11, 16'h0000);
    rc(6'h12, 16'h0000);
    rc(6'h15, 16'h0001);
    wr(6'h2a, 16'hffff);
    rc(6'h2a, 16'h0000);
    wr(6'h05, 16'h004f);
    rc(6'h05, 16'h004f);
    wr(6'h05, 16'h0000);
  endtask
  // Every trap source, every spacing code, slow and prompt accepts
  task automatic t_traps();
    seg = 8'h3c;
    wr(6'h10, {8'h00, seg});
    wr(6'h14, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      spc = 2'(i);
      dly = 2'(i);
      wr(6'h11, {14'h0000, spc});
      pt(i);
      offer(1'b1, i < 4 ? 7'(2 * i + 2) : 7'h0a);
      chk(irq, 1'b1);
      wr(6'h13, 16'h0001);
      #1 chk(irq, 1'b0);
      rc(6'h12, 16'h0001 << i);
      ret();
      rc(6'h12, 16'h0001 << i);
      wr(6'h12, 16'h0001 << i);
      rc(6'h12, 16'h0000);
    end
  endtask
  // Nesting by priority, trap over interrupt, blocked interrupts in trap
  task automatic t_nodes();
    logic [15:0] d;
    spc = 2'h1;
    wr(6'h11, 16'h0001);
    wr(6'h03, 16'h0045);
    wr(6'h07, 16'h0045);
    wr(6'h09, 16'h0049);
    wr(6'h0a, 16'h004f);
    pn(3);
    offer(1'b0, 7'h53);
    chk(cp, 4'h5);
    pn(7);
    noff(6);
    pn(9);
    offer(1'b0, 7'h59);
    pt(2);
    offer(1'b1, 7'h06);
    rd(6'h15, d);
    chk(d[2:0], 3'h4);
    pn(10);
    noff(6);
    ret();
    offer(1'b0, 7'h5a);
    ret();
    offer(1'b0, 7'h57);
    ret();
    chk(cp, 4'h0);
  endtask
  // Request bit set by software, and priority zero never served
  task automatic t_sw();
    rc(6'h13, 16'h0003);
    wr(6'h13, 16'h0003);
    wr(6'h14, 16'h0002);
    wr(6'h0c, 16'h00c3);
    offer(1'b0, 7'h5c);
    chk(irq, 1'b1);
    rc(6'h13, 16'h0002);
    ret();
    wr(6'h0d, 16'h00c0);
    noff(6);
  endtask

  // Main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_traps();
    t_nodes();
    t_sw();
    print_verdict();
  end

  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
endmodule
